/* File: rtl/pad_cell_ctrl.sv */
// One pad: chooses between fixed state and routed function, drives buffer
`timescale 1ns/1ps
`default_nettype none
`include "pad_mux_params.svh"

module pad_cell_ctrl #(
  parameter pad_mux_pkg::pad_state_t POR_STATE = pad_mux_pkg::ST_OFF
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic override_in,
  input wire pad_mux_pkg::pad_state_t state_in,
  input wire pad_mux_pkg::sel_t sel_in,
  input wire logic [`NUM_MODES-1:0] func_dout_in,
  input wire logic [`NUM_MODES-1:0] func_oe_in,
  input wire logic has_pulls_in,
  input wire logic pull_en_in,
  input wire logic pull_up_in,
  input wire logic toggle_in,
  output logic pad_dout_out,
  output logic pad_oe_out,
  output logic pull_up_out,
  output logic pull_dn_out
);
  import pad_mux_pkg::*;

  localparam logic [3:0] POR_DRIVE = drive_of(POR_STATE, 1'b0);
  localparam logic [`NUM_MODES-1:0] DEFINED = `MODE_DEFINED_MASK;

  logic [3:0] drive_d;
  logic [3:0] drive_q;
  logic routed_oe;

  // ==========================================================
  // Next buffer drive
  always_comb
  begin
    drive_d = 4'h0;
    routed_oe = 1'b0;
    if (override_in)
    begin
      drive_d = drive_of(state_in, toggle_in);
    end
    else
    begin
      // Undefined modes fall back to driver off, the safest guess
      if (DEFINED[sel_in] && sel_in != `MODE_DRV_OFF)
      begin
        routed_oe = func_oe_in[sel_in];
        drive_d[3] = routed_oe;
        drive_d[2] = func_dout_in[sel_in];
      end
      // Pulls only act on a released pad, never against our driver
      if (has_pulls_in && pull_en_in && !routed_oe)
      begin
        drive_d[1] = pull_up_in;
        drive_d[0] = !pull_up_in;
      end
    end
  end

  // Power-on state straight out of reset
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      drive_q <= POR_DRIVE;
    else
      drive_q <= drive_d;
  end

  assign pad_oe_out = drive_q[3];
  assign pad_dout_out = drive_q[2];
  assign pull_up_out = drive_q[1];
  assign pull_dn_out = drive_q[0];

endmodule
`default_nettype wire

/* File: rtl/pad_function_multiplexer.sv */
// Pad function multiplexer: selections, reset states, input steering
`timescale 1ns/1ps
`default_nettype none
`include "pad_mux_params.svh"

// What this block does
// - Select zero routes the pad's primary function
// - Selects one, two and fourteen route alternate functions
// - Warm reset release loads each pad's release selection
// - Driver-off selection tristates pad, input only
// - Unselected peripheral input gets fixed value or pad
// - Software enables or disables each pad's pulls
// - Power-on reset forces each pad's defined state
// - After release a pad may drive a clock
module pad_function_multiplexer (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic system_warm_output_reset_in,
  input wire logic cfg_wr_in,
  input wire logic [1:0] cfg_pad_in,
  input wire pad_mux_pkg::sel_t cfg_sel_in,
  input wire logic cfg_pull_en_in,
  input wire logic cfg_pull_up_in,
  input wire logic [`NUM_PADS-1:0] pad_in_in,
  input wire logic [`NUM_PADS-1:0][`NUM_MODES-1:0] func_dout_in,
  input wire logic [`NUM_PADS-1:0][`NUM_MODES-1:0] func_oe_in,
  output logic [`NUM_PADS-1:0] pad_dout_out,
  output logic [`NUM_PADS-1:0] pad_oe_out,
  output logic [`NUM_PADS-1:0] pull_up_en_out,
  output logic [`NUM_PADS-1:0] pull_dn_en_out,
  output logic [`NUM_INPUTS-1:0] periph_in_out,
  output pad_mux_pkg::sel_t [`NUM_PADS-1:0] pad_config_register_out,
  output logic [`NUM_PADS-1:0] release_active_out
);
  import pad_mux_pkg::*;

  localparam logic [`NUM_PADS*`STATE_W-1:0] POR_TAB = `PAD_POR_STATES;
  localparam logic [`NUM_PADS*`STATE_W-1:0] REL_TAB = `PAD_REL_STATES;
  localparam logic [`NUM_PADS*`SEL_W-1:0] REL_MODES = `PAD_REL_MODES;
  localparam logic [`NUM_PADS-1:0] PULL_MASK = `PAD_PULL_MASK;
  localparam logic [`NUM_INPUTS-1:0] DESEL_DEF = `DESEL_DEFINED_MASK;
  localparam logic [`NUM_INPUTS-1:0] DESEL_VAL = `DESEL_VALUES;

  sel_t [`NUM_PADS-1:0] sel_q, sel_d;
  logic [`NUM_PADS-1:0] ovr_q, ovr_d;
  pad_state_t [`NUM_PADS-1:0] ovr_state_q, ovr_state_d;
  logic [`NUM_PADS-1:0] pull_en_q, pull_en_d;
  logic [`NUM_PADS-1:0] pull_up_q, pull_up_d;
  logic [`NUM_INPUTS-1:0] periph_q, periph_d;
  logic warm_q;
  logic toggle_q;
  logic warm_fall;

  // ==========================================================
  // Pad configuration state
  // Warm reset is a synchronous level, so one stage finds its edge
  assign warm_fall = warm_q && !system_warm_output_reset_in;

  always_comb
  begin
    sel_d = sel_q;
    ovr_d = ovr_q;
    ovr_state_d = ovr_state_q;
    pull_en_d = pull_en_q;
    pull_up_d = pull_up_q;
    for (int p = 0; p < `NUM_PADS; p++)
    begin
      if (system_warm_output_reset_in)
      begin
        ovr_d[p] = 1'b1;
        ovr_state_d[p] = pad_state_t'(POR_TAB[p*`STATE_W +: `STATE_W]);
      end
      else if (warm_fall)
      begin
        // Release beats a write landing in the same cycle
        sel_d[p] = REL_MODES[p*`SEL_W +: `SEL_W];
        ovr_d[p] = 1'b1;
        ovr_state_d[p] = pad_state_t'(REL_TAB[p*`STATE_W +: `STATE_W]);
      end
      else if (cfg_wr_in && cfg_pad_in == 2'(p))
      begin
        sel_d[p] = cfg_sel_in;
        ovr_d[p] = 1'b0;
        pull_en_d[p] = cfg_pull_en_in;
        pull_up_d[p] = cfg_pull_up_in;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sel_q <= REL_MODES;
      ovr_q <= '1;
      // Per-pad cast, since a flat vector does not assign to enum fields
      for (int p = 0; p < `NUM_PADS; p++)
        ovr_state_q[p] <= pad_state_t'(POR_TAB[p*`STATE_W +: `STATE_W]);
      pull_en_q <= '0;
      pull_up_q <= '0;
      warm_q <= 1'b1;
      toggle_q <= 1'b0;
    end
    else
    begin
      sel_q <= sel_d;
      ovr_q <= ovr_d;
      ovr_state_q <= ovr_state_d;
      pull_en_q <= pull_en_d;
      pull_up_q <= pull_up_d;
      warm_q <= system_warm_output_reset_in;
      toggle_q <= !toggle_q; // Half-rate clock for clocking pads
    end
  end

  // ==========================================================
  // Peripheral input steering
  // Two pads on one input: the higher pad wins, software must avoid it
  always_comb
  begin
    logic hit;
    hit = 1'b0;
    periph_d = '0;
    for (int f = 0; f < `NUM_INPUTS; f++)
    begin
      hit = 1'b0;
      for (int p = 0; p < `NUM_PADS; p++)
      begin
        if (in_selected(2'(p), sel_q[p], 3'(f)))
        begin
          hit = 1'b1;
          periph_d[f] = pad_in_in[p];
        end
      end
      if (!hit)
        periph_d[f] = DESEL_DEF[f] ? DESEL_VAL[f] : pad_in_in[f % 4];
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      periph_q <= DESEL_VAL;
    else
      periph_q <= periph_d;
  end

  // ==========================================================
  // Pad cells
  for (genvar g = 0; g < `NUM_PADS; g++)
  begin : g_pad
    pad_cell_ctrl #(
      .POR_STATE(pad_state_t'(POR_TAB[g*`STATE_W +: `STATE_W]))
    ) u_cell (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .override_in(ovr_q[g]),
      .state_in(ovr_state_q[g]),
      .sel_in(sel_q[g]),
      .func_dout_in(func_dout_in[g]),
      .func_oe_in(func_oe_in[g]),
      .has_pulls_in(PULL_MASK[g]),
      .pull_en_in(pull_en_q[g]),
      .pull_up_in(pull_up_q[g]),
      .toggle_in(toggle_q),
      .pad_dout_out(pad_dout_out[g]),
      .pad_oe_out(pad_oe_out[g]),
      .pull_up_out(pull_up_en_out[g]),
      .pull_dn_out(pull_dn_en_out[g])
    );
  end

  assign periph_in_out = periph_q;
  assign pad_config_register_out = sel_q;
  assign release_active_out = ovr_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence warm_fall_s;
    warm_q && !system_warm_output_reset_in;
  endsequence

  sequence pull_write_s;
    cfg_wr_in && cfg_pad_in == 2'h2 && cfg_sel_in == `MODE_DRV_OFF &&
      cfg_pull_en_in && cfg_pull_up_in && !warm_q &&
      !system_warm_output_reset_in;
  endsequence

  release_load_a: assert property (warm_fall_s |=>
    sel_q[0] == 4'hf && ovr_q[0] && ovr_state_q[2] == ST_CLK)
    else $error("release selection not loaded");
  primary_route_a: assert property (
    !ovr_q[0] && sel_q[0] == 4'h0 |=>
    pad_oe_out[0] == $past(func_oe_in[0][0]) &&
    pad_dout_out[0] == $past(func_dout_in[0][0]))
    else $error("primary function not routed");
  alt_route_a: assert property (
    !ovr_q[1] && sel_q[1] == 4'h1 |=>
    pad_oe_out[1] == $past(func_oe_in[1][1]) &&
    pad_dout_out[1] == $past(func_dout_in[1][1]))
    else $error("alternate function not routed");
  driver_off_a: assert property (
    !ovr_q[2] && sel_q[2] == 4'hf |=> !pad_oe_out[2])
    else $error("driver off pad is driving");
  deselect_fixed_a: assert property (
    sel_q[0] != 4'h1 |=> periph_in_out[4] == 1'b1)
    else $error("deselected input not fixed high");
  deselect_pad_a: assert property (
    sel_q[3] != 4'h1 |=> periph_in_out[7] == $past(pad_in_in[3]))
    else $error("deselected input not following pad");
  pull_write_a: assert property (pull_write_s |=> ##1
    pull_up_en_out[2] && !pull_dn_en_out[2] && !pad_oe_out[2])
    else $error("programmed pull not applied");
  por_state_a: assert property (
    system_warm_output_reset_in |=> ##1
    pull_up_en_out[0] && !pad_oe_out[0] && pull_dn_en_out[1])
    else $error("reset state not shown");
  drive_no_pull_a: assert property (
    (pad_oe_out & (pull_up_en_out | pull_dn_en_out)) == '0)
    else $error("pull active while driving");
  release_clock_a: assert property (
    (ovr_q[2] && ovr_state_q[2] == ST_CLK) [*2] |=>
    pad_oe_out[2] && pad_dout_out[2] != $past(pad_dout_out[2]))
    else $error("release clock not toggling");
  sel_write_a: assert property (
    cfg_wr_in && cfg_pad_in == 2'h3 && !warm_q &&
    !system_warm_output_reset_in |=>
    sel_q[3] == $past(cfg_sel_in) && !ovr_q[3])
    else $error("selection write lost");

endmodule
`default_nettype wire

/* File: shared/pad_mux_params.svh */
// Constants for the pad function multiplexer: sizes, codes, reset tables
`ifndef PAD_MUX_PARAMS_SVH
`define PAD_MUX_PARAMS_SVH

// ==========================================================
// Sizes
`define NUM_PADS 4
`define NUM_MODES 16
`define SEL_W 4
`define STATE_W 6
`define NUM_INPUTS 8

// ==========================================================
// Selection values
`define MODE_PRIMARY 4'h0
`define MODE_ALT_IN 4'h1
`define MODE_ALT_NEIGHBOUR 4'h2
`define MODE_DRV_OFF 4'hf
// Modes that exist on every pad: 0, 1, 2, 14, 15
`define MODE_DEFINED_MASK 16'hc007

// ==========================================================
// Per-pad tables, pad 3 in the top field
// Power-on states: off, pulled down, pulled down, pulled up
`define PAD_POR_STATES {6'h04, 6'h08, 6'h08, 6'h10}
// Release states: pulled down, clock, drive high, pulled up
`define PAD_REL_STATES {6'h08, 6'h20, 6'h02, 6'h10}
`define PAD_REL_MODES 16'he00f
`define PAD_PULL_MASK 4'hf

// ==========================================================
// Deselected input values; inputs outside the mask follow the pad
`define DESEL_DEFINED_MASK 8'h70
`define DESEL_VALUES 8'h50

`endif

/* File: shared/pad_mux_pkg.sv */
// Types and shared decode functions of the pad function multiplexer
`include "pad_mux_params.svh"

package pad_mux_pkg;

  // ==========================================================
  // Fixed pad states, one-hot
  typedef enum logic [`STATE_W-1:0] {
    ST_DRV0 = 6'h01,
    ST_DRV1 = 6'h02,
    ST_OFF  = 6'h04,
    ST_PD   = 6'h08,
    ST_PU   = 6'h10,
    ST_CLK  = 6'h20
  } pad_state_t;

  typedef logic [`SEL_W-1:0] sel_t;

  // Fixed state to {oe, out, pull up, pull down}
  function automatic logic [3:0] drive_of(input pad_state_t st,
                                          input logic toggle);
    logic [3:0] d;
    d = 4'h0;
    unique case (st)
      ST_DRV0: d = 4'b1000;
      ST_DRV1: d = 4'b1100;
      ST_OFF:  d = 4'b0000;
      ST_PD:   d = 4'b0001;
      ST_PU:   d = 4'b0010;
      ST_CLK:  d = {1'b1, toggle, 2'b00};
      default: d = 4'b0000;
    endcase
    return d;
  endfunction

  // True when pad p with selection s feeds peripheral input f
  function automatic logic in_selected(input logic [1:0] p,
                                       input sel_t s,
                                       input logic [2:0] f);
    logic hit;
    hit = 1'b0;
    if (f[2])
    begin
      hit = (p == f[1:0]) && (s == `MODE_ALT_IN);
    end
    else
    begin
      hit = ((p == f[1:0]) && (s == `MODE_PRIMARY)) ||
            ((p == 2'(f[1:0] - 2'h1)) && (s == `MODE_ALT_NEIGHBOUR));
    end
    return hit;
  endfunction

endpackage

/* File: test/board_lines.sv */
// Board-side model of the pad lines: drivers, pulls and floating wires
`timescale 1ns/1ps
`default_nettype none
module board_lines (
  input wire logic clock_in,
  input wire logic [3:0] oe_in,
  input wire logic [3:0] dout_in,
  input wire logic [3:0] pu_in,
  input wire logic [3:0] pd_in,
  output logic [3:0] level_out
);
  logic [3:0] last_q = 4'h0;
  // ==========================================================
  // Line level: driver, then pull, else flips so stale data never reads
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (oe_in[i])
        level_out[i] = dout_in[i];
      else if (pu_in[i])
        level_out[i] = 1'b1;
      else if (pd_in[i])
        level_out[i] = 1'b0;
      else
        level_out[i] = ~last_q[i];
    end
  end
  // Remember the last level of each line
  always_ff @(posedge clock_in)
    last_q <= level_out;
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench of the pad function multiplexer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pad_mux_pkg::*;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic warm = 1'b1;
  logic cfg_wr = 1'b0;
  logic [1:0] cfg_pad = 2'h0;
  sel_t cfg_sel = 4'h0;
  logic pull_en = 1'b0;
  logic pull_up = 1'b0;
  logic [3:0][15:0] func_dout = '0;
  logic [3:0][15:0] func_oe = '0;
  logic [3:0] pad_in, dout, oe, pu, pd, rel;
  logic [7:0] periph;
  sel_t [3:0] sel_out;
  int errors = 0;
  int checks = 0;
  // ==========================================================
  // Clock and instances
  always #12.5 clock_in = ~clock_in;
  pad_function_multiplexer DUT (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .system_warm_output_reset_in(warm), .cfg_wr_in(cfg_wr),
    .cfg_pad_in(cfg_pad), .cfg_sel_in(cfg_sel), .cfg_pull_en_in(pull_en),
    .cfg_pull_up_in(pull_up), .pad_in_in(pad_in), .func_dout_in(func_dout),
    .func_oe_in(func_oe), .pad_dout_out(dout), .pad_oe_out(oe),
    .pull_up_en_out(pu), .pull_dn_en_out(pd), .periph_in_out(periph),
    .pad_config_register_out(sel_out), .release_active_out(rel));
  board_lines board (.clock_in(clock_in), .oe_in(oe), .dout_in(dout),
    .pu_in(pu), .pd_in(pd), .level_out(pad_in));
  // ==========================================================
  // Shared tasks
  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  // One write, then wait until the pins have followed
  task automatic wr(input logic [1:0] p, input sel_t s, input logic en,
                    input logic up);
    @(negedge clock_in);
    cfg_wr = 1'b1;
    cfg_pad = p;
    cfg_sel = s;
    pull_en = en;
    pull_up = up;
    @(negedge clock_in);
    cfg_wr = 1'b0;
    wait_n(2);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_por();
    chk("sel", 16'he00f, sel_out);
    chk("rel", 16'h000f, rel);
    chk("oe", 16'h0000, oe);
    chk("pu", 16'h0001, pu);
    chk("pd", 16'h0006, pd);
    chk("periph", 16'h0050, periph);
  endtask
  task automatic t_release();
    logic d0;
    warm = 1'b0;
    wait_n(3);
    chk("sel", 16'he00f, sel_out);
    chk("oe", 16'h0006, oe);
    chk("dout1", 16'h0001, dout[1]);
    chk("pu", 16'h0001, pu);
    chk("pd", 16'h0008, pd);
    chk("periph", 16'h0053, periph & 8'hfb);
    d0 = dout[2];
    wait_n(1);
    chk("clk", {15'h0000, !d0}, dout[2]);
  endtask
  task automatic t_route();
    sel_t modes [4] = '{4'h0, 4'h1, 4'h2, 4'he};
    func_oe[0] = 16'hffff;
    func_dout[0] = 16'h4005;
    // Defined modes only; mode 2 puts pads 0 and 1 both on input 1
    foreach (modes[i])
    begin
      wr(2'h0, modes[i], 1'b0, 1'b0);
      chk("rel0", 16'h0000, rel[0]);
      chk("oe0", 16'h0001, oe[0]);
      chk("dout0", 16'(func_dout[0][modes[i]]), dout[0]);
      if (modes[i] == 4'h1)
        chk("f4", 16'h0000, periph[4]);
    end
    // Alternate route on pad 1 also feeds its input function
    func_oe[1] = 16'h0002;
    func_dout[1] = 16'h0002;
    wr(2'h1, 4'h1, 1'b0, 1'b0);
    chk("oe1", 16'h0001, oe[1]);
    chk("dout1", 16'h0001, dout[1]);
    chk("f5", 16'h0001, periph[5]);
    // Pad 3 leaves its release state with a pull up
    wr(2'h3, 4'he, 1'b1, 1'b1);
    chk("rel3", 16'h0000, rel[3]);
    chk("sel3", 16'h000e, sel_out[3]);
    chk("pu3", 16'h0001, pu[3]);
  endtask
  task automatic t_drvoff();
    wr(2'h2, 4'hf, 1'b1, 1'b1);
    chk("oe2", 16'h0000, oe[2]);
    chk("pu2", 16'h0001, pu[2]);
    chk("pd2", 16'h0000, pd[2]);
    wr(2'h2, 4'hf, 1'b1, 1'b0);
    chk("pd2", 16'h0001, pd[2]);
    wr(2'h2, 4'hf, 1'b0, 1'b0);
    chk("pulls2", 16'h0000, {pu[2], pd[2]});
  endtask
  // Writes under warm reset are dropped; release reloads the defaults
  task automatic t_warm();
    warm = 1'b1;
    wait_n(3);
    chk("oe", 16'h0000, oe);
    chk("pu", 16'h0001, pu);
    wr(2'h1, 4'he, 1'b0, 1'b0);
    // Selections stand untouched until the release edge
    chk("sel", 16'hef1e, sel_out);
    warm = 1'b0;
    wait_n(3);
    chk("sel", 16'he00f, sel_out);
    chk("rel", 16'h000f, rel);
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    wait_n(11);
    t_por();
    wait_n(1);
    rst_n_in = 1'b1;
    wait_n(2);
    t_release();
    t_route();
    t_drvoff();
    t_warm();
    give_verdict();
  end
  initial
  begin
    #(400 * 25);
    errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
